// *** rtl/rbcps_regs.svh ***
// Constants for the read bit clock phase select block
`ifndef RBCPS_REGS_SVH
`define RBCPS_REGS_SVH

`define RBCPS_PHASE_NS       100
`define RBCPS_CLK_NS         4
`define RBCPS_PHASE_CYC      ((`RBCPS_PHASE_NS) / (`RBCPS_CLK_NS))
`define RBCPS_INDEX_NS       600
`define RBCPS_INDEX_CYC      ((`RBCPS_INDEX_NS) / (`RBCPS_CLK_NS))
`define RBCPS_MISS_DEFAULT   3
`define RBCPS_PHASE_NONE     4'h0
`define RBCPS_CNT_W          8

`endif

// *** rtl/rbcps_pkg.sv ***
// Types shared by the read bit clock phase select block
package rbcps_pkg;

	typedef enum logic [2:0] {
		RBCPS_ST_WRITE = 3'b001,
		RBCPS_ST_ADDR  = 3'b010,
		RBCPS_ST_SEG   = 3'b100
	} rbcps_mode_t;

	typedef struct packed {
		logic [3:0] phase;
		logic       edge_seen;
	} rbcps_phase_t;

endpackage : rbcps_pkg

// *** rtl/rbcps_phase_gen.sv ***
// Four phase pulse generator driven from the clock track level
`timescale 1ns/1ps
`include "rbcps_regs.svh"

module rbcps_phase_gen
	import rbcps_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         track_level,
	output rbcps_phase_t      phase_o
);

	typedef struct packed {
		logic       level_d;
		logic [7:0] cnt;
		logic [3:0] phase;
		logic       edge_seen;
	} rbcps_pg_state_t;

	rbcps_pg_state_t s_r;
	rbcps_pg_state_t s_nxt;

	////////////////////////////////////////////////////////////////////////
	// Rising edge of the level starts phase zero; each phase lasts a fixed
	// count, so the four pulses never overlap. A bit time longer than four
	// phases leaves a quiet gap rather than a fifth pulse.
	always_comb begin
		s_nxt           = s_r;
		s_nxt.level_d   = track_level;
		s_nxt.edge_seen = track_level & ~s_r.level_d;
		if (track_level & ~s_r.level_d) begin
			s_nxt.phase = 4'h1;
			s_nxt.cnt   = 8'h00;
		end else if (s_r.phase != 4'h0) begin
			if (s_r.cnt == 8'(`RBCPS_PHASE_CYC - 1)) begin
				s_nxt.cnt   = 8'h00;
				s_nxt.phase = {s_r.phase[2:0], 1'b0};
			end else begin
				s_nxt.cnt = s_r.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign phase_o.phase     = s_r.phase;
	assign phase_o.edge_seen = s_r.edge_seen;

	chk_phase_onehot: assert property (@(posedge clk) disable iff (!rst_n)
		$onehot0(s_r.phase)) else $error("phase pulses overlap");

endmodule : rbcps_phase_gen

// *** rtl/rbcps_top.sv ***
// Read bit clock generator with phase latch and dead space detection
`timescale 1ns/1ps
`include "rbcps_regs.svh"

// Summary of operation
// - Make four equal non-overlapping phase pulses from the clock track level.
// - In a segment read, latch the phase coinciding with the first data bit.
// - Once one latch is set, drop the arming gate until the next clear.
// - Bit clock is the phase two steps after the latched one.
// - Latch two set gives bit clock from phase zero; other gates stay off.
// - Keep phase for the segment, clear between segments, relatch next lead bit.
// - During writes and address reads latches clear, bit clock from phase zero.
// - Dead space level low while phase zero pulses arrive, high when they stop.
// - Entering dead space gives one 600 ns index pulse.
// - Each phase pulse is about 100 ns wide.
// - Read data captured in a flop, then shifted on each bit clock.
module rbcps_top
	import rbcps_pkg::*;
#(
	parameter logic [7:0] MISS_LIMIT = 8'(`RBCPS_MISS_DEFAULT)
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        CLOCK_TRACK_LEVEL,
	input  wire logic        READ_DATA_IN,
	input  wire logic        WRITE_MODE,
	input  wire logic        INFO_TRACK_SEL,
	input  wire logic        SEGMENT_CLEAR,
	output logic             BIT_CLOCK_PULSE,
	output logic [3:0]       PHASE_PULSES,
	output logic [3:0]       PHASE_LATCH,
	output logic             LATCH_ARM_GATE,
	output logic             READ_DATA_FLOP,
	output logic [7:0]       STACK_UP,
	output logic             DEAD_SPACE_LEVEL,
	output logic             GAP_INDEX_PULSE
);

	typedef struct packed {
		logic [3:0] latch;
		logic       rd_flop;
		logic [7:0] stack;
		logic [7:0] period_cnt;
		logic [7:0] bit_len;
		logic [7:0] since_edge;
		logic [7:0] miss_cnt;
		logic       dead;
		logic [7:0] index_cnt;
		logic       index;
		logic       bclk;
	} rbcps_state_t;

	rbcps_state_t s_r;
	rbcps_state_t s_nxt;
	rbcps_phase_t ph;
	rbcps_mode_t  mode;
	logic         seg_read;
	logic         arm;
	logic         p0;
	logic         bclk_c;

	////////////////////////////////////////////////////////////////////////
	// Phase pulse source
	rbcps_phase_gen rbcps_phase_gen_i (
		.clk         (CLK),
		.rst_n       (RST_N),
		.track_level (CLOCK_TRACK_LEVEL),
		.phase_o     (ph)
	);

	// Rotate a latch pattern by two phases to pick the gated pulse
	function automatic logic [3:0] rbcps_sel(input logic [3:0] l);
		rbcps_sel = {l[1:0], l[3:2]};
	endfunction : rbcps_sel

	always_comb begin
		if (WRITE_MODE) begin
			mode = RBCPS_ST_WRITE;
		end else if (!INFO_TRACK_SEL) begin
			mode = RBCPS_ST_ADDR;
		end else begin
			mode = RBCPS_ST_SEG;
		end
	end

	assign seg_read = (mode == RBCPS_ST_SEG) & ~SEGMENT_CLEAR;
	assign arm      = seg_read & (s_r.latch == `RBCPS_PHASE_NONE);
	assign p0       = ph.phase[0];

	// Gate the chosen phase; with no latch set, phase zero is used
	always_comb begin
		if (s_r.latch == `RBCPS_PHASE_NONE) begin
			bclk_c = p0;
		end else begin
			bclk_c = |(rbcps_sel(s_r.latch) & ph.phase);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt      = s_r;
		// Edge of the gated pulse forms a one-cycle bit clock
		s_nxt.bclk = bclk_c;
		if (bclk_c & ~s_r.bclk) begin
			s_nxt.rd_flop = READ_DATA_IN;
			s_nxt.stack   = {s_r.stack[6:0], s_r.rd_flop};
		end
		// Latch only while armed; the first one-bit freezes the choice
		if (!seg_read) begin
			s_nxt.latch = `RBCPS_PHASE_NONE;
		end else if (arm & READ_DATA_IN & (ph.phase != 4'h0)) begin
			s_nxt.latch = ph.phase;
		end
		// Track bit length in clocks so a missing pulse is counted by time.
		// The length comes from a counter that only a phase zero start resets,
		// kept apart from the miss timer: the track may be high when reset
		// lifts, giving a short first interval, and the true length then
		// replaces it at the next start instead of shrinking further.
		// Limitation: a bit time beyond 255 clocks saturates the measure.
		if (ph.edge_seen) begin
			s_nxt.bit_len    = s_r.since_edge;
			s_nxt.since_edge = 8'h00;
			s_nxt.period_cnt = 8'h00;
			s_nxt.miss_cnt   = 8'h00;
			s_nxt.dead       = 1'b0;
		end else begin
			if (s_r.since_edge != 8'hff) begin
				s_nxt.since_edge = s_r.since_edge + 8'h01;
			end
			// Miss timer rolls once per expected bit time
			if (s_r.period_cnt >= s_r.bit_len && s_r.bit_len != 8'h00) begin
				s_nxt.period_cnt = 8'h00;
				if (s_r.miss_cnt != 8'hff) begin
					s_nxt.miss_cnt = s_r.miss_cnt + 8'h01;
				end
				if (s_r.miss_cnt + 8'h01 >= MISS_LIMIT) begin
					s_nxt.dead = 1'b1;
				end
			end else if (s_r.period_cnt != 8'hff) begin
				s_nxt.period_cnt = s_r.period_cnt + 8'h01;
			end
		end
		// One index pulse on the rising edge of dead space
		if (s_nxt.dead & ~s_r.dead) begin
			s_nxt.index     = 1'b1;
			s_nxt.index_cnt = 8'h00;
		end else if (s_r.index) begin
			if (s_r.index_cnt == 8'(`RBCPS_INDEX_CYC - 1)) begin
				s_nxt.index = 1'b0;
			end else begin
				s_nxt.index_cnt = s_r.index_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign BIT_CLOCK_PULSE  = bclk_c;
	assign PHASE_PULSES     = ph.phase;
	assign PHASE_LATCH      = s_r.latch;
	assign LATCH_ARM_GATE   = arm;
	assign READ_DATA_FLOP   = s_r.rd_flop;
	assign STACK_UP         = s_r.stack;
	assign DEAD_SPACE_LEVEL = s_r.dead;
	assign GAP_INDEX_PULSE  = s_r.index;

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_latch_onehot: assert property (@(posedge CLK) disable iff (!RST_N)
		$onehot0(s_r.latch)) else $error("more than one phase latch set");

	chk_latch_hold: assert property (@(posedge CLK) disable iff (!RST_N)
		(s_r.latch != 4'h0) && seg_read |=> $stable(s_r.latch)) else $error("latch changed");

	chk_latch_two: assert property (@(posedge CLK) disable iff (!RST_N)
		s_r.latch == 4'h4 |-> BIT_CLOCK_PULSE == ph.phase[0]) else $error("latch two gating");

	chk_sel_rot: assert property (@(posedge CLK) disable iff (!RST_N)
		s_r.latch == 4'h2 |-> BIT_CLOCK_PULSE == ph.phase[3]) else $error("latch one gating");

	chk_write_clr: assert property (@(posedge CLK) disable iff (!RST_N)
		WRITE_MODE |=> s_r.latch == 4'h0 && BIT_CLOCK_PULSE == ph.phase[0])
		else $error("latch not clear in write");

	chk_seg_clear: assert property (@(posedge CLK) disable iff (!RST_N)
		SEGMENT_CLEAR |=> s_r.latch == 4'h0) else $error("latch not cleared");

	chk_dead_clear: assert property (@(posedge CLK) disable iff (!RST_N)
		ph.edge_seen |=> !DEAD_SPACE_LEVEL) else $error("dead space not cleared");

	sequence s_dead_rise;
		$rose(DEAD_SPACE_LEVEL);
	endsequence

	chk_index_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
		s_dead_rise |-> GAP_INDEX_PULSE) else $error("no index pulse");

	// Pulse must still stand on its last cycle and be gone one cycle later
	chk_index_len: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(GAP_INDEX_PULSE) |-> ##149 GAP_INDEX_PULSE ##1 !GAP_INDEX_PULSE)
		else $error("index length");

	// An index pulse only ever starts together with dead space
	chk_index_cause: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(GAP_INDEX_PULSE) |-> $rose(DEAD_SPACE_LEVEL))
		else $error("index without dead space");

	// Dead space needs the configured run of missed bit times
	chk_dead_miss: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(DEAD_SPACE_LEVEL) |-> s_r.miss_cnt >= MISS_LIMIT)
		else $error("dead space too early");

	// An armed latch takes the phase active when the one-bit arrived
	chk_latch_take: assert property (@(posedge CLK) disable iff (!RST_N)
		arm && READ_DATA_IN && (ph.phase != 4'h0) |=> s_r.latch == $past(ph.phase))
		else $error("latch took wrong phase");

	sequence s_bclk_rise;
		bclk_c && !s_r.bclk;
	endsequence

	// Data goes through the flop first, then one place down the stack
	chk_stack_shift: assert property (@(posedge CLK) disable iff (!RST_N)
		s_bclk_rise |=> STACK_UP == {$past(STACK_UP[6:0]), $past(READ_DATA_FLOP)}
			&& READ_DATA_FLOP == $past(READ_DATA_IN))
		else $error("stack did not shift");

endmodule : rbcps_top

// *** sim/rbcps_track_model.sv ***
// Clock track and read data source standing at the far side of the block
`timescale 1ns/1ps
module rbcps_track_model (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic       data_en,
	input  wire logic       data_all,
	input  wire logic [6:0] data_at,
	output logic            level,
	output logic            data
);
	logic [6:0] cnt_r = 7'h00;
	// One bit time is 100 cycles; the track stands still when stopped, as in dead space
	always_ff @(posedge clk) begin
		cnt_r <= (run && cnt_r != 7'h63) ? cnt_r + 7'h01 : 7'h00;
	end
	// Level high for the first half of each bit time
	assign level = run && (cnt_r < 7'h32);
	// Six cycle data window inside one phase, or data held high throughout
	assign data = data_en && (data_all || (cnt_r >= data_at && cnt_r < data_at + 7'h06));
endmodule : rbcps_track_model

// *** sim/read_bit_clock_phase_select_bench.sv ***
// Self-checking bench for the read bit clock phase select block
`timescale 1ns/1ps
`include "rbcps_regs.svh"
module read_bit_clock_phase_select_bench;
	logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, info = 1'b0, seg_clr = 1'b0;
	logic       run = 1'b1, den = 1'b0, dall = 1'b0, level, rdata, bclk, arm, rdf, dead, gidx;
	logic [6:0] dat = 7'h00;
	logic [3:0] ph, lat;
	logic [7:0] stk;
	int         miscompares = 0, num_checks = 0;
	rbcps_top rbcps_top_i (.CLK(clk), .RST_N(rst_n), .CLOCK_TRACK_LEVEL(level),
		.READ_DATA_IN(rdata), .WRITE_MODE(wr), .INFO_TRACK_SEL(info),
		.SEGMENT_CLEAR(seg_clr), .BIT_CLOCK_PULSE(bclk), .PHASE_PULSES(ph),
		.PHASE_LATCH(lat), .LATCH_ARM_GATE(arm), .READ_DATA_FLOP(rdf), .STACK_UP(stk),
		.DEAD_SPACE_LEVEL(dead), .GAP_INDEX_PULSE(gidx));
	rbcps_track_model rbcps_track_model_i (.clk(clk), .run(run), .data_en(den),
		.data_all(dall), .data_at(dat), .level(level), .data(rdata));
	////////////////////////////////////////////////////////////////////////////
	// Inputs always move 1 ns after the rising edge, clear of sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// Bounded wait for the first cycle of a phase zero pulse
	task automatic wait_p0;
		int i;
		i = 0;
		while (ph[0] === 1'b1 && i < 300) begin tick(1); i++; end
		while (ph[0] !== 1'b1 && i < 300) begin tick(1); i++; end
		if (i >= 300) begin chk(1'b0, "no phase pulse"); wrap_up(); end
	endtask : wait_p0
	////////////////////////////////////////////////////////////////////////////
	task automatic t_phases;
		int w;
		w = 0;
		wait_p0();
		while (ph[0] === 1'b1 && w < 50) begin tick(1); w++; end
		chk(w == `RBCPS_PHASE_CYC, "phase width");
		for (int k = 1; k < 4; k++) begin
			tick(12);
			chk(ph === (4'h1 << k), "phase order");
			tick(13);
		end
		wait_p0();
		tick(12);
		chk(bclk === 1'b1 && lat === 4'h0, "address read clock");
		chk(dead === 1'b0 && gidx === 1'b0, "dead while running");
		$display("t_phases done");
	endtask : t_phases
	// Latch on phase k, then the gated phase must be two steps later
	task automatic t_latch(input int k);
		int b;
		b = (k + 2) % 4;
		seg_clr = 1'b1;
		tick(2);
		seg_clr = 1'b0;
		info = 1'b1;
		dat = 7'(12 + 25 * k);
		den = 1'b1;
		tick(250);
		chk(lat === (4'h1 << k) && arm === 1'b0, "latch");
		dat = 7'(12 + 25 * b);
		tick(200);
		chk(lat === (4'h1 << k), "latch moved");
		den = 1'b0;
		wait_p0();
		tick(12 + 25 * b);
		chk(bclk === 1'b1, "gated phase");
		tick(25);
		chk(bclk === 1'b0, "gate off");
		seg_clr = 1'b1;
		tick(2);
		seg_clr = 1'b0;
		tick(1);
		chk(lat === 4'h0 && arm === 1'b1, "clear");
		$display("t_latch %0d done", k);
	endtask : t_latch
	task automatic t_write;
		wr = 1'b1;
		dat = 7'h25;
		den = 1'b1;
		tick(250);
		chk(lat === 4'h0, "write latch");
		wait_p0();
		tick(12);
		chk(bclk === 1'b1, "write clock");
		wr = 1'b0;
		info = 1'b0;
		dall = 1'b1;
		tick(1000);
		chk(stk === 8'hff && rdf === 1'b1, "stack up");
		den = 1'b0;
		dall = 1'b0;
		wait_p0();
		tick(1);
		chk(rdf === 1'b0 && stk === 8'hff, "read flop first");
		wait_p0();
		tick(1);
		chk(rdf === 1'b0 && stk === 8'hfe, "stack order");
		$display("t_write done");
	endtask : t_write
	task automatic t_dead;
		int n;
		n = 0;
		run = 1'b0;
		while (dead !== 1'b1 && n < 1000) begin tick(1); n++; end
		chk(n > 150 && n < 400, "dead space");
		chk(gidx === 1'b1, "index start");
		n = 0;
		while (gidx === 1'b1 && n < 400) begin tick(1); n++; end
		chk(n == `RBCPS_INDEX_CYC, "index width");
		run = 1'b1;
		n = 0;
		while (dead !== 1'b0 && n < 300) begin tick(1); n++; end
		chk(n < 300 && gidx === 1'b0, "dead clear");
		$display("t_dead done");
	endtask : t_dead
	////////////////////////////////////////////////////////////////////////////
	// Clock of 4 ns
	initial begin
		forever #2 clk = ~clk;
	end
	// Main sequence
	initial begin
		tick(8);
		chk(ph === 4'h0 && dead === 1'b0 && gidx === 1'b0, "reset");
		rst_n = 1'b1;
		tick(10);
		t_phases();
		for (int k = 0; k < 4; k++) t_latch(k);
		t_write();
		t_dead();
		wrap_up();
	end
endmodule : read_bit_clock_phase_select_bench
